// File: logic/ebh_pkg.sv
// Purpose: Shared constants and types for the external bus halt and arbitration block
// Assumes: 16-bit external data bus, active-low pins
// Notes: Show-cycle encodings and state enums live here
`default_nettype none

package ebh_pkg;

  // ----------------------------------------------------------
  // Show-cycle control field
  // ----------------------------------------------------------
  localparam logic [1:0] SHOW_OFF = 2'h0;
  localparam logic [1:0] SHOW_ON = 2'h1;
  localparam logic [1:0] SHOW_HALT = 2'h2;
  localparam logic [1:0] SHOW_RST = SHOW_OFF;

  // ----------------------------------------------------------
  // Transfer sizes in bytes and reset values
  // ----------------------------------------------------------
  localparam logic [2:0] XFER_NONE = 3'h0;
  localparam logic [2:0] XFER_BYTE = 3'h1;
  localparam logic [2:0] XFER_WORD = 3'h2;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [5:0] PIN_N_RST = 6'h3f;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ----------------------------------------------------------
  // State machines
  // ----------------------------------------------------------
  typedef enum logic [2:0] {BC_IDLE, BC_ADDR, BC_STRB, BC_TERM, BC_STOP, BC_RETRY} ebh_bc_state_type;
  typedef enum logic [1:0] {AR_IDLE, AR_GRANT, AR_OWNED, AR_REGRANT} ebh_arb_state_type;

endpackage : ebh_pkg

`default_nettype wire

// File: logic/ebh_arb_if.sv
// Purpose: Carrier between bus controller and arbiter
// Assumes: All signals on i_mclk
// Notes: req and ack are already synchronised
`default_nettype none

interface ebh_arb_if;
  logic req;
  logic ack;
  logic idle_ok;
  logic grant;
  logic float;
  modport arb (input req, input ack, input idle_ok, output grant, output float);
  modport ctl (output req, output ack, output idle_ok, input grant, input float);
endinterface : ebh_arb_if

`default_nettype wire

// File: logic/ebh_sync.sv
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to i_mclk
// Notes: Only the second stage is visible outside
`default_nettype none

module ebh_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= INIT;
      o_q <= INIT;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end

endmodule : ebh_sync

`default_nettype wire

// File: logic/ebh_arb.sv
// Purpose: Bus arbiter, device has lowest priority
// Assumes: Request and acknowledge are synchronised and active high
// Notes: grant is registered one clock after the state that changes it
`default_nettype none

module ebh_arb import ebh_pkg::*; (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Controller side
  ebh_arb_if.arb arb
);

  ebh_arb_state_type st_reg;
  ebh_arb_state_type st_next;
  logic grant_reg;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      AR_IDLE: begin
        if (arb.req && arb.idle_ok) begin
          st_next = AR_GRANT;
        end
      end
      AR_GRANT: begin
        if (arb.ack) begin
          st_next = AR_OWNED;
        end else if (!arb.req) begin
          st_next = AR_IDLE;
        end
      end
      AR_OWNED: begin
        if (!arb.ack) begin
          st_next = AR_IDLE;
        end else if (arb.req) begin
          st_next = AR_REGRANT;
        end
      end
      AR_REGRANT: begin
        if (!arb.ack) begin
          st_next = arb.req ? AR_GRANT : AR_IDLE;
        end
      end
      default: st_next = AR_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= AR_IDLE;
      grant_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      grant_reg <= (st_reg == AR_GRANT) || (st_reg == AR_REGRANT);
    end
  end

  assign arb.grant = grant_reg;
  assign arb.float = (st_reg != AR_IDLE);

endmodule : ebh_arb

`default_nettype wire

// File: logic/ebh_top.sv
// Purpose: External bus controller with stop handshake, arbitration and show cycles
// Assumes: One clock i_mclk at 250 MHz; pins are active low; 16-bit data bus
// Notes: Output enables are active low; all outputs are registered
`default_nettype none

module ebh_top import ebh_pkg::*; #(
  parameter int ADDR_W = 24
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // CPU external cycle request
  input wire logic i_cyc_req,
  input wire logic i_cyc_rw,
  input wire logic [ADDR_W-1:0] i_cyc_addr,
  input wire logic [2:0] i_cyc_fc,
  input wire logic [2:0] i_cyc_size,
  input wire logic [31:0] i_cyc_wdata,
  input wire logic i_locked_rmw_cycle,
  // CPU cycle answers
  output logic o_cyc_done,
  output logic o_cyc_err,
  output logic [31:0] o_cyc_rdata,
  output logic o_stop_hold,
  output logic o_int_stall,
  // Internal bus activity
  input wire logic i_int_valid,
  input wire logic [ADDR_W-1:0] i_int_addr,
  input wire logic [2:0] i_int_fc,
  input wire logic [1:0] i_int_size,
  input wire logic i_int_rw,
  input wire logic [15:0] i_int_data,
  // Show-cycle control
  input wire logic i_show_wr,
  input wire logic [1:0] i_show_cycle_enable,
  // Bus termination pins
  input wire logic [1:0] i_data_size_ack_n,
  input wire logic i_bus_error_n,
  input wire logic i_stop_req_n,
  // Arbitration pins
  input wire logic i_bus_request_n,
  input wire logic i_grant_ack_n,
  output logic o_bus_grant_n,
  // Address and control pins
  output logic o_address_strobe_n,
  output logic o_data_strobe_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic [2:0] o_fc,
  output logic [1:0] o_transfer_size,
  output logic o_rw,
  output logic o_ctl_oe_n,
  // Data pins
  input wire logic [15:0] i_data,
  output logic [15:0] o_data,
  output logic o_data_oe_n
);

  // ----------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------
  if (ADDR_W < 16 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 16 and 32");
  end

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [21:0] sy;

  ebh_sync #(
    .W(22),
    .INIT({DATA_RST, PIN_N_RST})
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_d({i_data, i_grant_ack_n, i_bus_request_n, i_stop_req_n, i_bus_error_n, i_data_size_ack_n}),
    .o_q(sy)
  );

  wire [1:0] s_data_size_ack_n = sy[1:0];
  wire s_bus_error = ~sy[2];
  wire s_halt = ~sy[3];
  wire s_req = ~sy[4];
  wire s_ack = ~sy[5];
  wire [15:0] s_d = sy[21:6];

  // ----------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------
  ebh_arb_if arb_if ();

  ebh_arb u_arb (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .arb(arb_if.arb)
  );

  ebh_bc_state_type st_reg;
  ebh_bc_state_type st_next;

  wire float = arb_if.float;
  wire bc_between = (st_reg == BC_IDLE) || (st_reg == BC_STOP) || (st_reg == BC_RETRY);

  assign arb_if.req = s_req;
  assign arb_if.ack = s_ack;
  assign arb_if.idle_ok = bc_between && !i_locked_rmw_cycle;

  // ----------------------------------------------------------
  // Cycle registers
  // ----------------------------------------------------------
  logic [2:0] rem_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [2:0] fc_reg;
  logic rw_reg;
  logic [31:0] wsh_reg;
  logic [31:0] rdat_reg;
  logic [1:0] show_reg;

  wire ack_any = ~&s_data_size_ack_n;
  wire port8 = s_data_size_ack_n[1];
  // A request still high beside done or err belongs to the finished operand
  wire req_new = i_cyc_req && !o_cyc_done && !o_cyc_err;
  wire start = (st_reg == BC_IDLE) && req_new && !float && !s_halt && !s_req && !s_bus_error;
  wire resume = !float && !s_req && !s_halt && !s_bus_error;
  wire cap = (st_reg == BC_STRB) && ack_any && !s_bus_error;
  wire [2:0] nb = (port8 || rem_reg == XFER_BYTE) ? XFER_BYTE : XFER_WORD;
  wire [7:0] byte_in = (port8 || !addr_reg[0]) ? s_d[15:8] : s_d[7:0];
  wire [5:0] align = 6'h20 - {i_cyc_size, 3'h0};

  wire [31:0] wsh_init = i_cyc_wdata << align;
  wire [31:0] wsh_cap = (nb == XFER_BYTE) ? {wsh_reg[23:0], 8'h00} : {wsh_reg[15:0], 16'h0000};
  wire [31:0] rdat_cap = (nb == XFER_BYTE) ? {rdat_reg[23:0], byte_in} : {rdat_reg[15:0], s_d};

  wire [2:0] rem_next = start ? i_cyc_size : (cap ? rem_reg - nb : rem_reg);
  wire [ADDR_W-1:0] addr_next = start ? i_cyc_addr : (cap ? addr_reg + ADDR_W'(nb) : addr_reg);
  wire [2:0] fc_next = start ? i_cyc_fc : fc_reg;
  wire rw_next = start ? i_cyc_rw : rw_reg;
  wire [31:0] wsh_next = start ? wsh_init : (cap ? wsh_cap : wsh_reg);
  wire [31:0] rdat_next = start ? WORD_RST : (cap ? rdat_cap : rdat_reg);
  wire [1:0] show_next = i_show_wr ? i_show_cycle_enable : show_reg;

  // ----------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      BC_IDLE: begin
        if (start) begin
          st_next = BC_ADDR;
        end
      end
      BC_ADDR: st_next = BC_STRB;
      BC_STRB: begin
        if (s_bus_error && s_halt) begin
          st_next = BC_RETRY;
        end else if (s_bus_error) begin
          st_next = BC_IDLE;
        end else if (ack_any) begin
          st_next = BC_TERM;
        end
      end
      BC_TERM: begin
        if (!ack_any) begin
          if (rem_reg == XFER_NONE) begin
            st_next = BC_IDLE;
          end else if (s_halt && !rem_reg[0]) begin
            st_next = BC_STOP;
          end else begin
            st_next = BC_ADDR;
          end
        end
      end
      BC_STOP: begin
        if (resume) begin
          st_next = BC_ADDR;
        end
      end
      BC_RETRY: begin
        if (resume) begin
          st_next = BC_ADDR;
        end
      end
      default: st_next = BC_IDLE;
    endcase
  end

  // ----------------------------------------------------------
  // Pin next values
  // ----------------------------------------------------------
  wire ext_nx = (st_next != BC_IDLE);
  wire show_now = (show_reg != SHOW_OFF) && i_int_valid && !ext_nx && !float;
  wire wr_drv = ext_nx && !rw_next && (st_next == BC_ADDR || st_next == BC_STRB);
  wire in_cycle = (st_next == BC_ADDR) || (st_next == BC_STRB) || (st_next == BC_TERM);

  wire as_n_nx = !(st_next == BC_STRB);
  wire ds_n_nx = !((st_next == BC_STRB) || show_now);
  wire load_pin = (st_next == BC_ADDR);
  wire hold_pin = ext_nx || float || !i_int_valid;
  wire [ADDR_W-1:0] addr_pin = load_pin ? addr_next : (hold_pin ? o_addr : i_int_addr);
  wire [2:0] fc_pin = load_pin ? fc_next : (hold_pin ? o_fc : i_int_fc);
  wire [1:0] siz_pin = load_pin ? rem_next[1:0] : (hold_pin ? o_transfer_size : i_int_size);
  wire rw_pin = load_pin ? rw_next : (hold_pin ? o_rw : i_int_rw);
  wire [15:0] wr_word = (rem_next == XFER_BYTE) ? {wsh_next[31:24], wsh_next[31:24]} : wsh_next[31:16];
  wire [15:0] data_pin = show_now ? i_int_data : wr_word;
  wire data_oe_n_nx = !(!float && (wr_drv || show_now));

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= BC_IDLE;
      rem_reg <= XFER_NONE;
      addr_reg <= '0;
      fc_reg <= 3'h0;
      rw_reg <= 1'b1;
      wsh_reg <= WORD_RST;
      rdat_reg <= WORD_RST;
      show_reg <= SHOW_RST;
    end else begin
      st_reg <= st_next;
      rem_reg <= rem_next;
      addr_reg <= addr_next;
      fc_reg <= fc_next;
      rw_reg <= rw_next;
      wsh_reg <= wsh_next;
      rdat_reg <= rdat_next;
      show_reg <= show_next;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_address_strobe_n <= 1'b1;
      o_data_strobe_n <= 1'b1;
      o_addr <= '0;
      o_fc <= 3'h0;
      o_transfer_size <= 2'h0;
      o_rw <= 1'b1;
      o_ctl_oe_n <= 1'b1;
      o_data <= DATA_RST;
      o_data_oe_n <= 1'b1;
    end else begin
      o_address_strobe_n <= as_n_nx;
      o_data_strobe_n <= ds_n_nx;
      o_addr <= addr_pin;
      o_fc <= fc_pin;
      o_transfer_size <= siz_pin;
      o_rw <= rw_pin;
      o_ctl_oe_n <= float;
      o_data <= data_pin;
      o_data_oe_n <= data_oe_n_nx;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_cyc_done <= 1'b0;
      o_cyc_err <= 1'b0;
      o_cyc_rdata <= WORD_RST;
      o_stop_hold <= 1'b0;
      o_int_stall <= 1'b0;
      o_bus_grant_n <= 1'b1;
    end else begin
      o_cyc_done <= (st_reg == BC_TERM) && !ack_any && (rem_reg == XFER_NONE);
      o_cyc_err <= (st_reg == BC_STRB) && s_bus_error && !s_halt;
      o_cyc_rdata <= rdat_next;
      o_stop_hold <= s_halt && !in_cycle;
      o_int_stall <= (show_reg == SHOW_HALT) && float;
      o_bus_grant_n <= !arb_if.grant;
    end
  end

endmodule : ebh_top

`default_nettype wire

// File: verification/ebh_top_monitor.sv
// Purpose: Arbitration, strobe and stop checks on the bus pins
// Assumes: One clock domain
// Notes: Bound into ebh_top
`default_nettype none

module ebh_top_monitor (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Inputs watched
  input wire logic i_cyc_req,
  input wire logic i_int_valid,
  input wire logic i_locked_rmw_cycle,
  input wire logic i_bus_request_n,
  input wire logic i_grant_ack_n,
  // Outputs watched
  input wire logic o_cyc_done,
  input wire logic o_stop_hold,
  input wire logic o_bus_grant_n,
  input wire logic o_address_strobe_n,
  input wire logic o_data_strobe_n,
  input wire logic o_ctl_oe_n,
  input wire logic o_data_oe_n
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  AST_GNT_LOCK: assert property ($fell(o_bus_grant_n) |->
    !($past(i_locked_rmw_cycle, 2) && $past(i_locked_rmw_cycle, 3))) else $error("Grant during lock");
  AST_GNT_REQ: assert property ($fell(o_bus_grant_n) |->
    !($past(i_bus_request_n, 3) && $past(i_bus_request_n, 4) && $past(i_bus_request_n, 5)))
    else $error("Grant without request");
  AST_GNT_IDLE: assert property ($fell(o_bus_grant_n) |-> o_address_strobe_n)
    else $error("Grant inside a transfer");
  AST_GNT_FLOAT: assert property ($fell(o_bus_grant_n) |-> o_ctl_oe_n && o_data_oe_n)
    else $error("Bus driven while granted");
  AST_GNT_DROP: assert property ($fell(o_bus_grant_n) |-> ##[1:40] o_bus_grant_n)
    else $error("Grant never dropped");
  AST_IDLE_ARB: assert property ((i_bus_request_n && i_grant_ack_n)[*8] |-> o_bus_grant_n)
    else $error("Grant while no request");
  AST_AS_EXT: assert property ($fell(o_address_strobe_n) |-> $past(i_cyc_req))
    else $error("Address strobe without external cycle");
  AST_STOP_AS: assert property (o_stop_hold |-> o_address_strobe_n)
    else $error("Strobe while stopped");
  AST_DS_CAUSE: assert property ($fell(o_data_strobe_n) |-> $past(i_cyc_req) || $past(i_int_valid))
    else $error("Data strobe without cycle");
  COV_GRANT: cover property ($fell(o_bus_grant_n));
  COV_STOP: cover property ($rose(o_stop_hold));
  COV_DONE: cover property (o_cyc_done);
endmodule : ebh_top_monitor

bind ebh_top ebh_top_monitor u_ebh_top_monitor (.i_mclk(i_mclk), .i_rst(i_rst), .i_cyc_req(i_cyc_req),
  .i_int_valid(i_int_valid), .i_locked_rmw_cycle(i_locked_rmw_cycle), .i_bus_request_n(i_bus_request_n),
  .i_grant_ack_n(i_grant_ack_n), .o_cyc_done(o_cyc_done), .o_stop_hold(o_stop_hold),
  .o_bus_grant_n(o_bus_grant_n), .o_address_strobe_n(o_address_strobe_n),
  .o_data_strobe_n(o_data_strobe_n), .o_ctl_oe_n(o_ctl_oe_n), .o_data_oe_n(o_data_oe_n));

`default_nettype wire

// File: verification/ebh_master.sv
// Purpose: External master and 16-bit memory port
// Assumes: Pins active low
// Notes: Released data lines show the inverse of the last value
`default_nettype none

module ebh_master (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Bench control
  input wire logic i_want,
  input wire logic [15:0] i_rdata,
  // Pins
  input wire logic i_bus_grant_n,
  input wire logic i_address_strobe_n,
  output logic o_bus_request_n,
  output logic o_grant_ack_n,
  output logic [1:0] o_data_size_ack_n,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold_reg;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_bus_request_n <= 1'b1;
      o_grant_ack_n <= 1'b1;
      hold_reg <= 4'h0;
    end else if (!o_grant_ack_n) begin
      hold_reg <= hold_reg + 4'h1;
      o_grant_ack_n <= (hold_reg == 4'hf);
    end else if (i_want && !i_bus_grant_n) begin
      o_grant_ack_n <= 1'b0;
      o_bus_request_n <= 1'b1;
    end else begin
      o_bus_request_n <= !i_want;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_data_size_ack_n <= 2'h3;
      o_data <= 16'h0000;
    end else if (!i_address_strobe_n) begin
      o_data_size_ack_n <= 2'h1;
      o_data <= i_rdata;
    end else begin
      o_data_size_ack_n <= 2'h3;
      o_data <= ~o_data;
    end
  end
endmodule : ebh_master

`default_nettype wire

// File: verification/test_ext_bus_halt_arbiter.sv
// Purpose: Self-checking bench for the bus halt and arbitration block
// Assumes: 4 ns clock
// Notes: Function codes, internal size and internal direction are tied
`default_nettype none

module test_ext_bus_halt_arbiter import ebh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0, i_rst = 1'b1, cyc_req = 1'b0, cyc_rw = 1'b1, lock = 1'b0, int_valid = 1'b0;
  logic show_wr = 1'b0, stop_n = 1'b1, want = 1'b0, bus_error_n = 1'b1;
  logic [23:0] cyc_addr = 24'h000000, int_addr = 24'h000000, out_addr;
  logic [2:0] cyc_size = 3'h1;
  logic [31:0] cyc_wdata = 32'h0, rdata;
  logic [15:0] int_data = 16'h0, mem_data = 16'h0, pin_data, out_data;
  logic [1:0] show_val = 2'h0, data_size_ack_n;
  logic br_n, ack_n, gnt_n, as_n, ds_n, ctl_oe_n, data_oe_n, done, hold, stall, err, out_rw;
  logic [2:0] out_fc;
  logic [1:0] out_siz;
  int fail_count = 0;
  int samples_checked = 0;
  always #2 i_mclk = ~i_mclk;
  ebh_top u_ebh_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_cyc_req(cyc_req), .i_cyc_rw(cyc_rw),
    .i_cyc_addr(cyc_addr), .i_cyc_fc(3'h5), .i_cyc_size(cyc_size), .i_cyc_wdata(cyc_wdata),
    .i_locked_rmw_cycle(lock), .o_cyc_done(done), .o_cyc_err(err), .o_cyc_rdata(rdata), .o_stop_hold(hold),
    .o_int_stall(stall), .i_int_valid(int_valid), .i_int_addr(int_addr), .i_int_fc(3'h5), .i_int_size(2'h2),
    .i_int_rw(1'b0), .i_int_data(int_data), .i_show_wr(show_wr), .i_show_cycle_enable(show_val),
    .i_data_size_ack_n(data_size_ack_n), .i_bus_error_n(bus_error_n), .i_stop_req_n(stop_n), .i_bus_request_n(br_n),
    .i_grant_ack_n(ack_n), .o_bus_grant_n(gnt_n), .o_address_strobe_n(as_n), .o_data_strobe_n(ds_n),
    .o_addr(out_addr), .o_fc(out_fc), .o_transfer_size(out_siz), .o_rw(out_rw),
    .o_ctl_oe_n(ctl_oe_n), .i_data(pin_data),
    .o_data(out_data), .o_data_oe_n(data_oe_n));
  ebh_master u_ebh_master (.i_mclk(i_mclk), .i_rst(i_rst), .i_want(want), .i_rdata(mem_data),
    .i_bus_grant_n(gnt_n), .i_address_strobe_n(as_n), .o_bus_request_n(br_n), .o_grant_ack_n(ack_n),
    .o_data_size_ack_n(data_size_ack_n), .o_data(pin_data));
  task automatic test_done();
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_sig(ref logic s, input logic lvl);
    int n = 0;
    while (s !== lvl && n < 300) begin
      @(posedge i_mclk);
      n++;
    end
    check(n < 300, 1'b1);
    if (n >= 300) test_done();
  endtask : wait_sig
  task automatic cpu_op(input logic rw, input logic [23:0] a, input logic [2:0] sz, input logic [31:0] wd);
    cyc_rw <= rw;
    cyc_addr <= a;
    cyc_size <= sz;
    cyc_wdata <= wd;
    @(posedge i_mclk);
    cyc_req <= 1'b1;
    wait_sig(done, 1'b1);
    cyc_req <= 1'b0;
  endtask : cpu_op
  task automatic int_cyc(input logic [15:0] d);
    int_valid <= 1'b1;
    int_addr <= {8'h00, d};
    int_data <= d;
    @(posedge i_mclk);
    int_valid <= 1'b0;
    @(posedge i_mclk);
  endtask : int_cyc
  task automatic set_show(input logic [1:0] v);
    show_val <= v;
    show_wr <= 1'b1;
    @(posedge i_mclk);
    show_wr <= 1'b0;
    @(posedge i_mclk);
  endtask : set_show
  task automatic arb_cycle();
    want <= 1'b1;
    wait_sig(gnt_n, 1'b0);
    check(ctl_oe_n, 1'b1);
    wait_sig(ack_n, 1'b0);
    want <= 1'b0;
    wait_sig(gnt_n, 1'b1);
    wait_sig(ack_n, 1'b1);
    wait_sig(ctl_oe_n, 1'b0);
    check(gnt_n, 1'b1);
  endtask : arb_cycle
  task automatic t_show();
    int_cyc(16'hf0f0);
    check({out_addr, out_fc, out_siz, out_rw}, {24'h00f0f0, 3'h5, 2'h2, 1'b0});
    check({as_n, ds_n, data_oe_n}, 3'h7);
    for (int v = 1; v < 4; v++) begin
      set_show(v[1:0]);
      int_cyc(16'h1234 + v[15:0]);
      check({as_n, ds_n, data_oe_n}, 3'h4);
      check(out_data, 16'h1234 + v[15:0]);
    end
    set_show(SHOW_HALT);
    fork
      arb_cycle();
      begin
        wait_sig(gnt_n, 1'b0);
        repeat (3) @(posedge i_mclk);
        check(stall, 1'b1);
      end
    join
    set_show(SHOW_OFF);
  endtask : t_show
  task automatic t_byte_write();
    fork
      cpu_op(1'b0, 24'h000101, 3'h1, 32'h000000c3);
      begin
        wait_sig(ds_n, 1'b0);
        check(out_data, 16'hc3c3);
      end
    join
  endtask : t_byte_write
  task automatic t_lock();
    lock <= 1'b1;
    want <= 1'b1;
    repeat (20) @(posedge i_mclk);
    check(gnt_n, 1'b1);
    lock <= 1'b0;
    arb_cycle();
  endtask : t_lock
  task automatic t_stop();
    stop_n <= 1'b0;
    wait_sig(hold, 1'b1);
    arb_cycle();
    check(out_addr, 24'h000101);
    mem_data <= 16'h5aa5;
    fork
      cpu_op(1'b1, 24'h000200, 3'h2, 32'h0);
      begin
        repeat (12) @(posedge i_mclk);
        check({as_n, data_oe_n, hold}, 3'h7);
        stop_n <= 1'b1;
      end
    join
    check(rdata, 32'h00005aa5);
    fork
      cpu_op(1'b1, 24'h000300, 3'h4, 32'h0);
      begin
        wait_sig(as_n, 1'b0);
        stop_n <= 1'b0;
        wait_sig(hold, 1'b1);
        check({as_n, ds_n, data_oe_n}, 3'h7);
        check({out_addr, out_fc, out_siz, out_rw}, {24'h000300, 3'h5, 2'h0, 1'b1});
        repeat (4) @(posedge i_mclk);
        stop_n <= 1'b1;
      end
    join
    check(rdata, 32'h5aa55aa5);
  endtask : t_stop
  task automatic t_bus_error();
    mem_data <= 16'hc33c;
    cyc_rw <= 1'b1;
    cyc_addr <= 24'h000400;
    cyc_size <= 3'h2;
    @(posedge i_mclk);
    cyc_req <= 1'b1;
    wait_sig(as_n, 1'b0);
    bus_error_n <= 1'b0;
    wait_sig(err, 1'b1);
    cyc_req <= 1'b0;
    bus_error_n <= 1'b1;
    check(done, 1'b0);
    repeat (4) @(posedge i_mclk);
    fork
      cpu_op(1'b1, 24'h000400, 3'h2, 32'h0);
      begin
        wait_sig(as_n, 1'b0);
        bus_error_n <= 1'b0;
        stop_n <= 1'b0;
        repeat (8) @(posedge i_mclk);
        check({as_n, ds_n, hold, err}, 4'he);
        bus_error_n <= 1'b1;
        stop_n <= 1'b1;
      end
    join
    check(rdata, 32'h0000c33c);
  endtask : t_bus_error
  initial begin
    repeat (5) @(posedge i_mclk);
    check({gnt_n, as_n, ds_n, ctl_oe_n, data_oe_n}, 5'h1f);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    t_show();
    t_byte_write();
    arb_cycle();
    t_lock();
    t_stop();
    t_bus_error();
    test_done();
  end
endmodule : test_ext_bus_halt_arbiter

`default_nettype wire
